// ### nce_engine.sv
// Purpose: Flash erase, program and read, eeprom program and read engine
// Assumes: Register writes arrive as one-cycle cpu strobes
// Notes:   Flash work stalls the cpu, eeprom work runs in the background
//
// Summary of operation
// - 8K flash shared; boot size from option
// - Data region spans low bound to boot
// - Low bound from option or software
// - Eeprom work stalls the cpu only while a flash command is queued behind it
// - Done flag set after eeprom op, sticky
// - Writing one to control bit 0 clears done
// - Enable bit 7 gates all commands
// - Modes c8 program, c0 read, 00 standby
// - Mode c3 erases one 64-byte page
// - 64 loads in c2, then c1 commits
// - Mode 01 reads flash into data register
// - Keys 46 then b9 start a command
// - Busy holds until eeprom read data valid
// - Eeprom address wraps to nine bits
// - No carry from low into high address
// - Flash during eeprom waits, cpu stalled
// - Page erase address is page aligned
`timescale 1ns/1ps
`default_nettype none
module nce_engine
    import nce_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // Cpu register writes
    input  wire nce_sfr_wr_t           sfr,
    // Hardware options and cpu context
    input  wire logic [BOOT_SEL_W-1:0] boot_size_sel,
    input  wire logic [DW-1:0]         lb_option,
    input  wire logic                  cpu_in_boot,
    // Register views
    output logic      [DW-1:0]         mode_select_reg,
    output logic      [DW-1:0]         address_high_reg,
    output logic      [DW-1:0]         address_low_reg,
    output logic      [DW-1:0]         nvm_data_reg,
    output logic      [DW-1:0]         data_region_low_bound,
    output logic                       engine_enable_bit,
    // Status
    output logic                       engine_busy_flag,
    output logic                       eeprom_done_flag,
    output logic                       cpu_stall,
    output logic                       cmd_reject,
    output logic      [FL_AW:0]        boot_start_addr,
    // Flash array port
    output nce_fl_req_t                flash_req,
    input  wire nce_mem_rsp_t          flash_rsp,
    // Eeprom array port
    output nce_ee_req_t                ee_req,
    input  wire nce_mem_rsp_t          ee_rsp
);

    typedef struct packed {
        nce_state_t         st;
        logic               en;
        logic               done;
        logic [DW-1:0]      mode;
        logic [DW-1:0]      adrh;
        logic [DW-1:0]      adrl;
        logic [DW-1:0]      data;
        logic [DW-1:0]      lb;
        logic               lb_init;
        logic               pend;
        logic [DW-1:0]      pend_mode;
        logic [PAGE_AW-1:0] cnt;
        logic               reject;
        nce_fl_req_t        fl;
        nce_ee_req_t        ee;
    } nce_eng_t;

    nce_eng_t r;
    nce_eng_t n;

    logic               fire;
    logic [FL_AW-1:0]   fl_addr;
    logic [FL_AW-1:0]   pg_addr;
    logic [EE_AW-1:0]   ee_addr;
    logic [FL_AW:0]     boot_start;
    logic [FL_AW:0]     lb_addr;
    logic               wr_ok;
    logic               fl_trig;
    logic               pend_now;
    logic [DW-1:0]      pend_md;
    logic               latch_we;
    logic               latch_clr;
    logic [DW-1:0]      latch_rdata;

    // Flash mode codes
    function automatic logic is_flash(input logic [DW-1:0] md);
        is_flash = (md == MODE_FL_READ) || (md == MODE_FL_COMMIT) ||
                   (md == MODE_FL_LOAD) || (md == MODE_FL_ERASE);
    endfunction

    // Launch one flash command from idle
    function automatic nce_eng_t start_flash(
        input nce_eng_t         s,
        input logic [DW-1:0]    md,
        input logic [FL_AW-1:0] byte_addr,
        input logic [FL_AW-1:0] page_addr,
        input logic             allow
    );
        nce_eng_t t;
        t = s;
        case (md)
            MODE_FL_READ: begin
                t.st       = ST_FL_READ;
                t.fl.valid = 1'b1;
                t.fl.op    = FL_OP_READ;
                t.fl.addr  = byte_addr;
                t.fl.wdata = s.data;
            end
            MODE_FL_ERASE: begin
                if (allow) begin
                    t.st       = ST_FL_ERASE;
                    t.fl.valid = 1'b1;
                    t.fl.op    = FL_OP_ERASE;
                    t.fl.addr  = page_addr;
                    t.fl.wdata = ERASED_BYTE;
                end else begin
                    t.reject = 1'b1;
                end
            end
            MODE_FL_LOAD: begin
                t.st = ST_FL_LOAD;
            end
            MODE_FL_COMMIT: begin
                if (allow) begin
                    t.st       = ST_FL_PROG;
                    t.cnt      = PAGE_OFS0;
                    t.fl.valid = 1'b0;
                end else begin
                    t.reject = 1'b1;
                end
            end
            default: begin
                t.st = s.st;
            end
        endcase
        start_flash = t;
    endfunction

    // Unlock sequence, live only when enabled
    nce_key_seq u_keys (
        .clk      (clk),
        .resetn   (resetn),
        .key_wr   (sfr.key_wr),
        .key_data (sfr.wdata),
        .enable   (r.en),
        .fire     (fire)
    );

    // Page latch fed by load commands, drained by commit
    nce_page_latch u_latch (
        .clk    (clk),
        .resetn (resetn),
        .we     (latch_we),
        .waddr  (r.adrl[PAGE_AW-1:0]),
        .wdata  (r.data),
        .clr    (latch_clr),
        .raddr  (r.cnt),
        .rdata  (latch_rdata)
    );

    // Address forms; high bits beyond the array ignored
    assign fl_addr = {r.adrh[FL_HI_W-1:0], r.adrl};
    assign pg_addr = {fl_addr[FL_AW-1:PAGE_AW], PAGE_OFS0};
    assign ee_addr = {r.adrh[0], r.adrl};

    // Region bounds from boot option and low bound
    assign boot_start = FL_TOP - ((FL_AW + 1)'(boot_size_sel) << BOOT_UNIT_SHIFT);
    assign lb_addr    = (FL_AW + 1)'(r.lb) << LB_SHIFT;

    // Boot code may write below boot, application only its data region
    // The boot region itself is never writable here
    always_comb begin
        wr_ok = ({1'b0, pg_addr} < boot_start) &&
                (cpu_in_boot || ({1'b0, pg_addr} >= lb_addr));
    end

    // Flash trigger landing during eeprom work
    assign fl_trig  = fire && is_flash(r.mode);
    assign pend_now = r.pend || fl_trig;
    assign pend_md  = r.pend ? r.pend_mode : r.mode;

    // Latch write comes from the load state flop, so it trails by one; clear lands with the last commit ack
    assign latch_we  = (r.st == ST_FL_LOAD);
    assign latch_clr = (r.st == ST_FL_PROG) && r.fl.valid && flash_rsp.ack &&
                       (r.cnt == PAGE_LAST);

    // Next state
    always_comb begin
        n        = r;
        n.reject = 1'b0;

        // Option caught once after reset, software may overwrite
        if (!r.lb_init) begin
            n.lb      = lb_option;
            n.lb_init = 1'b1;
        end else if (sfr.lb_wr) begin
            n.lb = sfr.wdata;
        end

        // Control: enable, write-one clear of done
        if (sfr.ctrl_wr) begin
            n.en = sfr.wdata[CTRL_EN_BIT];
            if (sfr.wdata[CTRL_CLR_BIT]) begin
                n.done = 1'b0;
            end
        end

        // Plain register writes; no carry out of low
        if (sfr.mode_wr) begin
            n.mode = sfr.wdata;
        end
        if (sfr.adrh_wr) begin
            n.adrh = sfr.wdata;
        end
        if (sfr.adrl_wr) begin
            n.adrl = sfr.wdata;
        end
        if (sfr.data_wr) begin
            n.data = sfr.wdata;
        end

        unique case (r.st)
            ST_IDLE: begin
                if (fire) begin
                    if (r.mode == MODE_EE_PROG || r.mode == MODE_EE_READ) begin
                        n.st       = ST_EE;
                        n.ee.valid = 1'b1;
                        n.ee.we    = (r.mode == MODE_EE_PROG);
                        n.ee.addr  = ee_addr;
                        n.ee.wdata = r.data;
                    end else begin
                        // Standby, unknown codes do nothing
                        n = start_flash(n, r.mode, fl_addr, pg_addr, wr_ok);
                    end
                end
            end
            ST_EE: begin
                if (fl_trig) begin
                    n.pend      = 1'b1;
                    n.pend_mode = r.mode;
                end
                if (ee_rsp.ack) begin
                    n.ee.valid = 1'b0;
                    n.done     = 1'b1;
                    if (!r.ee.we) begin
                        n.data = ee_rsp.rdata;
                    end
                    if (pend_now) begin
                        n.pend = 1'b0;
                        n.st   = ST_IDLE;
                        n      = start_flash(n, pend_md, fl_addr, pg_addr, wr_ok);
                    end else begin
                        n.st = ST_IDLE;
                    end
                end
            end
            ST_FL_READ: begin
                if (flash_rsp.ack) begin
                    n.fl.valid = 1'b0;
                    n.data     = flash_rsp.rdata;
                    n.st       = ST_IDLE;
                end
            end
            ST_FL_ERASE: begin
                if (flash_rsp.ack) begin
                    n.fl.valid = 1'b0;
                    n.st       = ST_IDLE;
                end
            end
            ST_FL_LOAD: begin
                n.st = ST_IDLE;
            end
            ST_FL_PROG: begin
                // One byte per request, latch order, page base fixed
                if (!r.fl.valid) begin
                    n.fl.valid = 1'b1;
                    n.fl.op    = FL_OP_PROG;
                    n.fl.addr  = {pg_addr[FL_AW-1:PAGE_AW], r.cnt};
                    n.fl.wdata = latch_rdata;
                end else if (flash_rsp.ack) begin
                    n.fl.valid = 1'b0;
                    n.cnt      = r.cnt + 1'b1;
                    if (r.cnt == PAGE_LAST) begin
                        n.st = ST_IDLE;
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase

        // Set wins over a clear landing in the same cycle
        if (r.st == ST_EE && ee_rsp.ack) begin
            n.done = 1'b1;
        end
    end

    // Engine register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r.st        <= ST_IDLE;
            r.en        <= 1'b0;
            r.done      <= 1'b0;
            r.mode      <= MODE_STANDBY;
            r.adrh      <= BYTE_RST;
            r.adrl      <= BYTE_RST;
            r.data      <= BYTE_RST;
            r.lb        <= BYTE_RST;
            r.lb_init   <= 1'b0;
            r.pend      <= 1'b0;
            r.pend_mode <= MODE_STANDBY;
            r.cnt       <= PAGE_OFS0;
            r.reject    <= 1'b0;
            r.fl        <= '0;
            r.ee        <= '0;
        end else begin
            r <= n;
        end
    end

    // Register views
    assign mode_select_reg       = r.mode;
    assign address_high_reg      = r.adrh;
    assign address_low_reg       = r.adrl;
    assign nvm_data_reg          = r.data;
    assign data_region_low_bound = r.lb;
    assign engine_enable_bit     = r.en;
    assign eeprom_done_flag      = r.done;
    assign cmd_reject            = r.reject;
    assign boot_start_addr       = boot_start;

    // Busy covers eeprom and flash; stall covers flash and a flash command queued behind eeprom
    assign engine_busy_flag = (r.st != ST_IDLE);
    assign cpu_stall = r.pend || (r.st == ST_FL_READ) || (r.st == ST_FL_ERASE) ||
                       (r.st == ST_FL_LOAD) || (r.st == ST_FL_PROG);

    // Array requests straight from flops
    assign flash_req = r.fl;
    assign ee_req    = r.ee;

endmodule
`default_nettype wire

// ### nce_engine_bench.sv
// Purpose: Self-checking bench for nce_engine
// Assumes: Bench is the cpu and both arrays
// Notes:   Eeprom answers slowly so a flash command can queue
`timescale 1ns/1ps
`default_nettype none
module nce_engine_bench
    import nce_pkg::*;
;
    localparam logic [6:0] S_CTRL = 7'h40, S_MODE = 7'h20, S_ADRH = 7'h10, S_ADRL = 7'h08;
    localparam logic [6:0] S_DATA = 7'h04, S_KEY = 7'h02, S_LB = 7'h01;
    localparam int EE_LAT = 30;
    localparam int FL_LAT = 2;
    logic          clk = 1'b0;
    logic          resetn = 1'b0;
    nce_sfr_wr_t   sfr = '0;
    logic          cpu_in_boot = 1'b0;
    nce_mem_rsp_t  flash_rsp = '0;
    nce_mem_rsp_t  ee_rsp = '0;
    logic [DW-1:0] mode_q, ahi_q, alo_q, nvm_data_reg, lb_q;
    logic          en_q, engine_busy_flag, eeprom_done_flag, cpu_stall, cmd_reject;
    logic [FL_AW:0] boot_q;
    nce_fl_req_t   flash_req, fl_seen = '0;
    nce_ee_req_t   ee_req, ee_seen = '0;
    int            fails = 0, samples_checked = 0, ee_cnt = 0, fl_cnt = 0;
    int            prog_cnt = 0, prog_bad = 0;

    always #50 clk = ~clk;

    nce_engine i_nce_engine (.clk(clk), .resetn(resetn), .sfr(sfr),
        .boot_size_sel(3'h3), .lb_option(8'h80), .cpu_in_boot(cpu_in_boot),
        .mode_select_reg(mode_q), .address_high_reg(ahi_q), .address_low_reg(alo_q),
        .nvm_data_reg(nvm_data_reg), .data_region_low_bound(lb_q), .engine_enable_bit(en_q),
        .engine_busy_flag(engine_busy_flag), .eeprom_done_flag(eeprom_done_flag),
        .cpu_stall(cpu_stall), .cmd_reject(cmd_reject), .boot_start_addr(boot_q),
        .flash_req(flash_req), .flash_rsp(flash_rsp), .ee_req(ee_req), .ee_rsp(ee_rsp));

    // Array stand-ins, fixed latency
    always @(posedge clk) begin
        ee_rsp.ack   <= ee_req.valid && !ee_rsp.ack && ee_cnt == EE_LAT;
        ee_rsp.rdata <= ee_req.addr[7:0] ^ 8'ha5;
        ee_cnt       <= (ee_req.valid && !ee_rsp.ack && ee_cnt < EE_LAT) ? ee_cnt + 1 : 0;
        if (ee_req.valid) ee_seen <= ee_req;
    end
    always @(posedge clk) begin
        flash_rsp.ack   <= flash_req.valid && !flash_rsp.ack && fl_cnt == FL_LAT;
        flash_rsp.rdata <= flash_req.addr[7:0] ^ 8'h5a;
        fl_cnt <= (flash_req.valid && !flash_rsp.ack && fl_cnt < FL_LAT) ? fl_cnt + 1 : 0;
        if (flash_req.valid) fl_seen <= flash_req;
        // Commit walks the page in load order
        if (flash_req.valid && flash_rsp.ack && flash_req.op == FL_OP_PROG) begin
            prog_cnt <= prog_cnt + 1;
            if (flash_req.addr !== 13'h1080 + 13'(prog_cnt) || flash_req.wdata !== 8'(prog_cnt))
                prog_bad <= prog_bad + 1;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle strobe, then a gap cycle
    task automatic wr(input logic [6:0] stb, input logic [7:0] d);
        @(posedge clk);
        sfr <= nce_sfr_wr_t'({stb, d});
        @(posedge clk);
        sfr <= '0;
    endtask

    task automatic fire(input logic [7:0] m, input logic [7:0] hi, input logic [7:0] lo,
                        input logic [7:0] d);
        wr(S_CTRL, 8'h80);
        wr(S_MODE, m);
        wr(S_ADRH, hi);
        wr(S_ADRL, lo);
        wr(S_DATA, d);
        keys();
    endtask

    task automatic keys();
        wr(S_KEY, KEY_FIRST);
        wr(S_KEY, KEY_SECOND);
    endtask

    // Bounded wait for idle
    task automatic idle_wait();
        int n;
        n = 0;
        @(posedge clk);
        while (engine_busy_flag !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("busy wait", 16'(n == 1000), 16'h0000);
    endtask

    task automatic quiet();
        repeat (2) @(posedge clk);
        check("no start", 16'({engine_busy_flag, flash_req.valid, ee_req.valid}), 16'h0000);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard, well past the run length
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        check("low bound", 16'(lb_q), 16'h0080);
        check("boot start", 16'(boot_q), 16'h1a00);
        wr(S_LB, 8'h40);
        @(posedge clk);
        check("low bound sw", 16'(lb_q), 16'h0040);
        // Eeprom program, address above 0x1ff wraps
        fire(MODE_EE_PROG, 8'h03, 8'h45, 8'h96);
        @(posedge clk);
        check("ee busy stall", 16'({engine_busy_flag, cpu_stall}), 16'h0002);
        idle_wait();
        check("ee prog req", 16'({ee_seen.we, ee_seen.addr}), 16'h0345);
        check("ee prog data", 16'(ee_seen.wdata), 16'h0096);
        repeat (5) @(posedge clk);
        check("done sticky", 16'(eeprom_done_flag), 16'h0001);
        wr(S_CTRL, 8'h81);
        @(posedge clk);
        check("done clear", 16'(eeprom_done_flag), 16'h0000);
        // Eeprom read, then no carry
        fire(MODE_EE_READ, 8'h02, 8'hff, 8'h00);
        idle_wait();
        check("ee read data", 16'(nvm_data_reg), 16'h005a);
        check("ee read req", 16'({ee_seen.we, ee_seen.addr}), 16'h00ff);
        wr(S_ADRL, 8'h00);
        @(posedge clk);
        check("no carry", 16'({ahi_q, alo_q}), 16'h0200);
        wr(S_CTRL, 8'h81);
        // Ignored starts
        wr(S_CTRL, 8'h00);
        wr(S_MODE, MODE_FL_READ);
        keys();
        quiet();
        wr(S_CTRL, 8'h80);
        wr(S_KEY, KEY_FIRST);
        wr(S_KEY, 8'h00);
        wr(S_KEY, KEY_SECOND);
        quiet();
        wr(S_MODE, MODE_STANDBY);
        keys();
        quiet();
        // Flash read and page erase
        fire(MODE_FL_READ, 8'h01, 8'h23, 8'h00);
        idle_wait();
        check("fl read", 16'(nvm_data_reg), 16'h0079);
        check("fl read req", 16'({fl_seen.op, fl_seen.addr}), 16'h0123);
        fire(MODE_FL_ERASE, 8'h10, 8'h45, 8'h00);
        idle_wait();
        check("erase req", 16'({fl_seen.op, fl_seen.addr}), 16'h5040);
        fire(MODE_FL_ERASE, 8'h00, 8'h40, 8'h00);
        @(posedge clk);
        check("refused", 16'({cmd_reject, engine_busy_flag}), 16'h0002);
        cpu_in_boot <= 1'b1;
        fire(MODE_FL_ERASE, 8'h00, 8'h40, 8'h00);
        idle_wait();
        check("boot erase", 16'({fl_seen.op, fl_seen.addr}), 16'h4040);
        // Fill the page latch, then commit
        for (int i = 0; i < 64; i++) begin
            fire(MODE_FL_LOAD, 8'h10, 8'h80 + 8'(i), 8'(i));
            idle_wait();
        end
        fire(MODE_FL_COMMIT, 8'h10, 8'hbf, 8'h00);
        idle_wait();
        check("prog count", 16'(prog_cnt), 16'h0040);
        check("prog order", 16'(prog_bad), 16'h0000);
        // Flash read queued behind eeprom
        fire(MODE_EE_PROG, 8'h00, 8'h10, 8'h5a);
        fire(MODE_FL_READ, 8'h00, 8'h77, 8'h00);
        @(posedge clk);
        check("queued", 16'({cpu_stall, ee_req.valid, flash_req.valid}), 16'h0006);
        idle_wait();
        check("queued read", 16'(nvm_data_reg), 16'h002d);
        check("queued done", 16'(eeprom_done_flag), 16'h0001);
        wr(S_MODE, MODE_STANDBY);
        wr(S_CTRL, 8'h00);
        @(posedge clk);
        check("close", 16'({mode_q, en_q}), 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire

// ### nce_engine_chk.sv
// Purpose: Port assertions for nce_engine
// Assumes: One clock, async active-low reset
// Notes:   Bound to every nce_engine instance
`timescale 1ns/1ps
`default_nettype none
module nce_engine_chk
    import nce_pkg::*;
(
    // Clock and reset
    input wire logic          clk,
    input wire logic          resetn,
    // Cpu writes and register views
    input wire nce_sfr_wr_t   sfr,
    input wire logic [DW-1:0] address_high_reg,
    input wire logic [DW-1:0] address_low_reg,
    input wire logic [DW-1:0] nvm_data_reg,
    input wire logic          engine_enable_bit,
    // Status
    input wire logic          engine_busy_flag,
    input wire logic          eeprom_done_flag,
    input wire logic          cpu_stall,
    input wire logic          cmd_reject,
    // Array ports
    input wire nce_fl_req_t   flash_req,
    input wire nce_mem_rsp_t  flash_rsp,
    input wire nce_ee_req_t   ee_req,
    input wire nce_mem_rsp_t  ee_rsp
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Done flag set, kept, cleared
    a_done_set: assert property (ee_req.valid && ee_rsp.ack |=> eeprom_done_flag)
        else $error("done not set");
    a_done_keep: assert property (eeprom_done_flag && !(sfr.ctrl_wr && sfr.wdata[0])
        |=> eeprom_done_flag) else $error("done dropped");
    a_done_clear: assert property (sfr.ctrl_wr && sfr.wdata[0]
        && !(ee_req.valid && ee_rsp.ack) |=> !eeprom_done_flag) else $error("done not cleared");

    // Start needs enable and second key
    a_enable_gate: assert property (!engine_enable_bit && !engine_busy_flag
        |=> !engine_busy_flag) else $error("busy while off");
    a_key_start: assert property (!engine_busy_flag
        && !(sfr.key_wr && sfr.wdata == KEY_SECOND) |=> !engine_busy_flag)
        else $error("busy without key");

    // Eeprom wrap, busy, no stall
    a_ee_wrap: assert property ($rose(ee_req.valid) |-> ee_req.addr ==
        {$past(address_high_reg[0]), $past(address_low_reg)}) else $error("eeprom address");
    a_ee_busy: assert property (ee_req.valid |-> engine_busy_flag)
        else $error("ee not busy");
    a_ee_end: assert property (ee_req.valid && ee_rsp.ack && !cpu_stall
        |=> !engine_busy_flag) else $error("ee busy stuck");
    a_ee_free: assert property ($rose(ee_req.valid) |-> !cpu_stall)
        else $error("ee stalled cpu");

    // Flash stall, alignment, data, refusal
    a_fl_stall: assert property (flash_req.valid |-> cpu_stall)
        else $error("flash unstalled");
    a_erase_page: assert property (flash_req.valid && flash_req.op == FL_OP_ERASE
        |-> flash_req.addr[5:0] == 6'h00) else $error("erase unaligned");
    a_read_lands: assert property (flash_req.valid && flash_rsp.ack
        && flash_req.op == FL_OP_READ |=> nvm_data_reg == $past(flash_rsp.rdata))
        else $error("flash read lost");
    a_reject_quiet: assert property (cmd_reject |=> !engine_busy_flag && !cmd_reject)
        else $error("reject went busy");

    // Main scenarios reached
    c_ee_done: cover property (ee_req.valid && ee_rsp.ack);
    c_queued: cover property (ee_req.valid && cpu_stall);
    c_reject: cover property (cmd_reject);
endmodule

bind nce_engine nce_engine_chk i_nce_engine_chk (.clk(clk), .resetn(resetn), .sfr(sfr),
    .address_high_reg(address_high_reg), .address_low_reg(address_low_reg),
    .nvm_data_reg(nvm_data_reg), .engine_enable_bit(engine_enable_bit),
    .engine_busy_flag(engine_busy_flag), .eeprom_done_flag(eeprom_done_flag),
    .cpu_stall(cpu_stall), .cmd_reject(cmd_reject), .flash_req(flash_req),
    .flash_rsp(flash_rsp), .ee_req(ee_req), .ee_rsp(ee_rsp));
`default_nettype wire

// ### nce_key_seq.sv
// Purpose: Two-write unlock for the trigger key
// Assumes: key_wr is a one-cycle strobe
// Notes:   fire is a one-cycle combinational pulse
`timescale 1ns/1ps
`default_nettype none
module nce_key_seq
    import nce_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // Key writes
    input  wire logic          key_wr,
    input  wire logic [DW-1:0] key_data,
    input  wire logic          enable,
    // Trigger
    output logic               fire
);

    typedef struct packed {
        logic armed;
    } nce_key_t;

    nce_key_t r;
    nce_key_t n;

    // A stray byte or dropped enable disarms
    always_comb begin
        n    = r;
        fire = 1'b0;
        if (!enable) begin
            n.armed = 1'b0;
        end else if (key_wr) begin
            if (r.armed && key_data == KEY_SECOND) begin
                fire    = 1'b1;
                n.armed = 1'b0;
            end else begin
                n.armed = (key_data == KEY_FIRST);
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule
`default_nettype wire

// ### nce_page_latch.sv
// Purpose: 64-byte page latch for flash commit
// Assumes: one write or one clear per cycle
// Notes:   Read is a mux of flops, no extra latency
`timescale 1ns/1ps
`default_nettype none
module nce_page_latch
    import nce_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // Fill port
    input  wire logic               we,
    input  wire logic [PAGE_AW-1:0] waddr,
    input  wire logic [DW-1:0]      wdata,
    input  wire logic               clr,
    // Drain port
    input  wire logic [PAGE_AW-1:0] raddr,
    output logic      [DW-1:0]      rdata
);

    typedef struct packed {
        logic [PAGE_BYTES-1:0][DW-1:0] mem;
    } nce_latch_t;

    nce_latch_t r;
    nce_latch_t n;

    // Unloaded bytes stay erased so a partial page leaves flash as is
    always_comb begin
        n = r;
        if (clr) begin
            n.mem = {PAGE_BYTES{ERASED_BYTE}};
        end else if (we) begin
            n.mem[waddr] = wdata;
        end
    end

    assign rdata = r.mem[raddr];

    // Latch storage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r.mem <= {PAGE_BYTES{ERASED_BYTE}};
        end else begin
            r <= n;
        end
    end

endmodule
`default_nettype wire

// ### nce_pkg.sv
// Purpose: Constants and carriers for nce_engine
// Assumes: 8-bit register bytes, 8K flash, 512-byte eeprom
// Notes:   Mode codes and keys fixed by software flow
package nce_pkg;

    // Sizes
    localparam int DW         = 8;
    localparam int FL_AW      = 13;
    localparam int EE_AW      = 9;
    localparam int PAGE_AW    = 6;
    localparam int PAGE_BYTES = 64;
    localparam int FL_HI_W    = FL_AW - DW;
    localparam int BOOT_SEL_W = 3;

    // Flash geometry; top is one past the end
    localparam logic [FL_AW:0]     FL_TOP          = 14'h2000;
    localparam int                 BOOT_UNIT_SHIFT = 9;
    localparam int                 LB_SHIFT        = 5;
    localparam logic [PAGE_AW-1:0] PAGE_OFS0       = 6'h00;
    localparam logic [PAGE_AW-1:0] PAGE_LAST       = 6'h3f;

    // Mode select codes
    localparam logic [DW-1:0] MODE_STANDBY   = 8'h00;
    localparam logic [DW-1:0] MODE_FL_READ   = 8'h01;
    localparam logic [DW-1:0] MODE_FL_COMMIT = 8'hc1;
    localparam logic [DW-1:0] MODE_FL_LOAD   = 8'hc2;
    localparam logic [DW-1:0] MODE_FL_ERASE  = 8'hc3;
    localparam logic [DW-1:0] MODE_EE_READ   = 8'hc0;
    localparam logic [DW-1:0] MODE_EE_PROG   = 8'hc8;

    // Trigger keys and control bits
    localparam logic [DW-1:0] KEY_FIRST    = 8'h46;
    localparam logic [DW-1:0] KEY_SECOND   = 8'hb9;
    localparam int            CTRL_EN_BIT  = 7;
    localparam int            CTRL_CLR_BIT = 0;

    // Reset values
    localparam logic [DW-1:0] BYTE_RST    = 8'h00;
    localparam logic [DW-1:0] ERASED_BYTE = 8'hff;

    typedef enum logic [1:0] {
        FL_OP_READ  = 2'h0,
        FL_OP_PROG  = 2'h1,
        FL_OP_ERASE = 2'h2
    } nce_fl_op_t;

    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_EE       = 6'h02,
        ST_FL_READ  = 6'h04,
        ST_FL_ERASE = 6'h08,
        ST_FL_LOAD  = 6'h10,
        ST_FL_PROG  = 6'h20
    } nce_state_t;

    // Cpu write strobes, shared data byte
    typedef struct packed {
        logic          ctrl_wr;
        logic          mode_wr;
        logic          adrh_wr;
        logic          adrl_wr;
        logic          data_wr;
        logic          key_wr;
        logic          lb_wr;
        logic [DW-1:0] wdata;
    } nce_sfr_wr_t;

    typedef struct packed {
        logic             valid;
        nce_fl_op_t       op;
        logic [FL_AW-1:0] addr;
        logic [DW-1:0]    wdata;
    } nce_fl_req_t;

    typedef struct packed {
        logic             valid;
        logic             we;
        logic [EE_AW-1:0] addr;
        logic [DW-1:0]    wdata;
    } nce_ee_req_t;

    typedef struct packed {
        logic          ack;
        logic [DW-1:0] rdata;
    } nce_mem_rsp_t;

endpackage
